// file: rtl/pfs_top.sv
`timescale 1ns/1ps
module pfs_top #(
  parameter int OC_PERSIST = pfs_pkg::OC_PERSIST_CYC,
  parameter longint SLOW_PERSIST = pfs_pkg::SLOW_PERSIST_CYC,
  parameter int RESP_DELAY = pfs_pkg::RESP_DELAY_CYC,
  parameter int SELFTEST = pfs_pkg::SELFTEST_CYC,
  parameter int BLINK = pfs_pkg::BLINK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // programmed i/o commands, same clock
  input wire logic status_request_cmd,
  input wire logic status_read_cmd,
  input wire logic control_write_cmd,
  input wire logic clear_flag_cmd,
  input wire logic io_reset_cmd,
  input wire logic interrupt_acknowledge_cmd,
  input wire logic [15:0] acc_in,
  output logic [15:0] acc_out,
  output logic busy,
  output logic done,
  output logic irq,
  // asynchronous sensor pins
  input wire logic [5:0] fault_pins,
  input wire logic power_switch,
  input wire logic margin_jumper_flag,
  input wire logic partial_backup_present,
  input wire logic full_backup_present,
  input wire logic recharging_flag,
  input wire logic rom_checksum_bad,
  // power controls and display
  output logic power_enable,
  output logic on_battery_flag,
  output logic powerfail_nmi,
  output logic powerfail_flag,
  output logic [2:0] lamps
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [pfs_pkg::NP-1:0] pin_raw;
  logic [pfs_pkg::NP-1:0] s1_q;
  logic [pfs_pkg::NP-1:0] s2_q;
  logic [pfs_pkg::NP-1:0] s3_q;
  logic [pfs_pkg::NP-1:0] lvl_q;
  logic monitoring;
  logic [pfs_pkg::NF-1:0] hit;
  assign pin_raw = {rom_checksum_bad, recharging_flag, full_backup_present,
                    partial_backup_present, margin_jumper_flag, power_switch, fault_pins};

  genvar g;
  generate
    for (g = 0; g < pfs_pkg::NP; g++) begin : g_sync
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          lvl_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= pin_raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            lvl_q[g] <= s3_q[g];
          end
        end
      end
    end
    // ----------------------------------------
    // fault persistence, one timer per input
    // ----------------------------------------
    for (g = 0; g < pfs_pkg::NF; g++) begin : g_persist
      localparam logic [33:0] LIM = (g == pfs_pkg::F_OC) ? 34'(OC_PERSIST) :
                                    (g == pfs_pkg::F_TEMP || g == pfs_pkg::F_FAN) ?
                                    34'(SLOW_PERSIST) : 34'h0_0001;
      logic [33:0] cnt_q;
      logic fired_q;
      assign hit[g] = lvl_q[g] && monitoring && !fired_q && (cnt_q == LIM - 34'h0_0001);
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          cnt_q <= '0;
          fired_q <= 1'b0;
        end else if (!lvl_q[g] || !monitoring) begin
          cnt_q <= '0;
          fired_q <= 1'b0;
        end else if (hit[g]) begin
          fired_q <= 1'b1;
        end else if (!fired_q) begin
          cnt_q <= cnt_q + 34'h0_0001;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // fault event selection
  // ----------------------------------------
  logic fault_evt;
  logic [2:0] fault_idx;
  logic [6:0] fault_code;
  always_comb begin
    fault_evt = 1'b0;
    fault_idx = 3'h0;
    for (int i = pfs_pkg::NF - 1; i >= 0; i--) begin
      if (hit[i]) begin
        fault_evt = 1'b1;
        fault_idx = 3'(i);
      end
    end
  end
  // class in low bits of each code
  always_comb begin
    unique case (fault_idx)
      3'h0: fault_code = pfs_pkg::CODE_OV;
      3'h1: fault_code = pfs_pkg::CODE_OC;
      3'h2: fault_code = pfs_pkg::CODE_TEMP;
      3'h3: fault_code = pfs_pkg::CODE_FAN;
      3'h4: fault_code = pfs_pkg::CODE_UNREG;
      default: fault_code = pfs_pkg::CODE_BATT;
    endcase
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic pfmask_q;
  logic int_en_q;
  logic batt_off_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pfmask_q <= 1'b0;
      int_en_q <= 1'b0;
      batt_off_q <= 1'b0;
    end else if (io_reset_cmd) begin
      int_en_q <= 1'b0;
    end else if (control_write_cmd && !acc_in[pfs_pkg::CTL_ADDR_HI]
                 && !acc_in[pfs_pkg::CTL_ADDR_LO]) begin
      pfmask_q <= acc_in[pfs_pkg::CTL_PFMASK];
      int_en_q <= acc_in[pfs_pkg::CTL_INT];
      batt_off_q <= acc_in[pfs_pkg::CTL_BATT_OFF];
    end
  end

  // ----------------------------------------
  // power sequencing
  // ----------------------------------------
  pfs_pkg::pfs_pwr_t pwr_q;
  logic [31:0] test_cnt_q;
  logic [6:0] code_q;
  logic backup_ok;
  assign monitoring = (pwr_q == pfs_pkg::PWR_ON) || (pwr_q == pfs_pkg::PWR_BATT);
  assign backup_ok = (lvl_q[pfs_pkg::P_PARTIAL] || lvl_q[pfs_pkg::P_FULL]) && !batt_off_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwr_q <= pfs_pkg::PWR_OFF;
      test_cnt_q <= '0;
      powerfail_nmi <= 1'b0;
    end else begin
      powerfail_nmi <= 1'b0;
      if (!lvl_q[pfs_pkg::P_SW]) begin
        pwr_q <= pfs_pkg::PWR_OFF;
      end else begin
        unique case (pwr_q)
          pfs_pkg::PWR_OFF: begin
            pwr_q <= pfs_pkg::PWR_TEST;
            test_cnt_q <= '0;
          end
          pfs_pkg::PWR_TEST: begin
            if (test_cnt_q == 32'(SELFTEST - 1)) begin
              pwr_q <= lvl_q[pfs_pkg::P_ROM] ? pfs_pkg::PWR_DOWN : pfs_pkg::PWR_ON;
            end else begin
              test_cnt_q <= test_cnt_q + 32'h0000_0001;
            end
          end
          pfs_pkg::PWR_ON, pfs_pkg::PWR_BATT: begin
            if (fault_evt) begin
              unique case (fault_idx)
                3'h5: pwr_q <= pwr_q;
                // switch to battery or drop power
                3'h4: begin
                  if (backup_ok) begin
                    pwr_q <= pfs_pkg::PWR_BATT;
                  end else begin
                    pwr_q <= pfs_pkg::PWR_DOWN;
                    powerfail_nmi <= !pfmask_q;
                  end
                end
                default: pwr_q <= pfs_pkg::PWR_DOWN;
              endcase
            end else if (pwr_q == pfs_pkg::PWR_BATT && !lvl_q[pfs_pkg::F_UNREG]) begin
              pwr_q <= pfs_pkg::PWR_ON;
            end
          end
          pfs_pkg::PWR_DOWN: pwr_q <= pfs_pkg::PWR_DOWN;
          default: pwr_q <= pfs_pkg::PWR_OFF;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      power_enable <= 1'b0;
      on_battery_flag <= 1'b0;
      powerfail_flag <= 1'b0;
    end else begin
      power_enable <= monitoring;
      on_battery_flag <= (pwr_q == pfs_pkg::PWR_BATT);
      // alternate mode hides powerfail from skips
      powerfail_flag <= lvl_q[pfs_pkg::F_UNREG] && !pfmask_q && (pwr_q != pfs_pkg::PWR_BATT);
    end
  end

  // ----------------------------------------
  // latched fault code
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      code_q <= pfs_pkg::CODE_NONE;
    end else if (pwr_q == pfs_pkg::PWR_OFF && lvl_q[pfs_pkg::P_SW]) begin
      code_q <= pfs_pkg::CODE_LAMP;
    end else if (pwr_q == pfs_pkg::PWR_TEST && test_cnt_q == 32'(SELFTEST - 1)) begin
      code_q <= lvl_q[pfs_pkg::P_ROM] ? pfs_pkg::CODE_ROM : pfs_pkg::CODE_NONE;
    end else if (fault_evt) begin
      code_q <= fault_code;
    end
  end

  // ----------------------------------------
  // lamps, slow blink of the fault class
  // ----------------------------------------
  logic [31:0] blink_cnt_q;
  logic blink_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
      lamps <= 3'h0;
    end else begin
      if (blink_cnt_q == 32'(BLINK - 1)) begin
        blink_cnt_q <= '0;
        blink_q <= !blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
      end
      if (pwr_q == pfs_pkg::PWR_TEST) begin
        lamps <= pfs_pkg::LAMPS_ALL;
      end else begin
        lamps <= blink_q ? code_q[2:0] : 3'h0;
      end
    end
  end

  // ----------------------------------------
  // command handshake and selector
  // ----------------------------------------
  logic [2:0] sel_q;
  logic [31:0] resp_cnt_q;
  logic finish;
  assign finish = busy && (resp_cnt_q == 32'(RESP_DELAY - 1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_q <= pfs_pkg::SEL_CTRL;
    end else if (io_reset_cmd) begin
      sel_q <= pfs_pkg::SEL_CTRL;
    end else if (status_request_cmd) begin
      sel_q <= acc_in[2:0];
    end else if (fault_evt && int_en_q) begin
      sel_q <= pfs_pkg::SEL_FAULT;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      resp_cnt_q <= '0;
    end else if (status_request_cmd || control_write_cmd || !busy) begin
      resp_cnt_q <= '0;
    end else begin
      resp_cnt_q <= resp_cnt_q + 32'h0000_0001;
    end
  end

  // completion wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else if (io_reset_cmd) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      if (clear_flag_cmd) begin
        busy <= 1'b0;
        done <= 1'b0;
      end
      if (status_request_cmd || control_write_cmd) begin
        busy <= 1'b1;
        done <= 1'b0;
      end else if (finish) begin
        busy <= 1'b0;
        done <= 1'b1;
      end
      // fault raises done for the interrupt
      if (fault_evt && int_en_q) begin
        done <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= done && int_en_q && !io_reset_cmd && !clear_flag_cmd;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_out <= 16'h0000;
    end else if (interrupt_acknowledge_cmd && irq) begin
      acc_out <= pfs_pkg::DEVICE_CODE;
    end else if (status_read_cmd) begin
      acc_out <= 16'h0000;
      unique case (sel_q)
        pfs_pkg::SEL_CTRL: begin
          acc_out[pfs_pkg::CTL_JUMPER] <= lvl_q[pfs_pkg::P_JMP];
          acc_out[pfs_pkg::CTL_PFMASK] <= pfmask_q;
          acc_out[pfs_pkg::CTL_INT] <= int_en_q;
          acc_out[pfs_pkg::CTL_BATT_OFF] <= batt_off_q;
        end
        pfs_pkg::SEL_BATT: begin
          acc_out[pfs_pkg::BW_PARTIAL] <= lvl_q[pfs_pkg::P_PARTIAL];
          acc_out[pfs_pkg::BW_FULL] <= lvl_q[pfs_pkg::P_FULL];
          acc_out[pfs_pkg::BW_ON] <= (pwr_q == pfs_pkg::PWR_BATT);
          acc_out[pfs_pkg::BW_RECHARGE] <= lvl_q[pfs_pkg::P_RECHARGE];
        end
        pfs_pkg::SEL_FAULT: acc_out[6:0] <= code_q;
        pfs_pkg::SEL_REV: acc_out[7:0] <= pfs_pkg::FW_REVISION;
        default: acc_out <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_request;
    status_request_cmd && !io_reset_cmd;
  endsequence

  chk_request_busy: assert property (s_request |=> busy && !done)
    else $error("request did not set busy");
  chk_select_latch: assert property (s_request |=> sel_q == $past(acc_in[2:0]))
    else $error("selector not latched");
  chk_irq_follow: assert property (done && int_en_q && !io_reset_cmd && !clear_flag_cmd
    |=> irq) else $error("irq not raised");
  chk_clear_flags: assert property (clear_flag_cmd && !status_request_cmd
    && !control_write_cmd && !fault_evt |=> !busy && !done) else $error("clear failed");
  chk_ack_code: assert property (interrupt_acknowledge_cmd && irq
    |=> acc_out == pfs_pkg::DEVICE_CODE) else $error("bad device code");
  chk_ov_immediate: assert property (fault_evt && fault_idx == 3'h0
    |=> pwr_q == pfs_pkg::PWR_DOWN ##1 !power_enable) else $error("overvoltage kept power");
  chk_batt_fault: assert property (fault_evt && fault_idx == 3'h5
    && lvl_q[pfs_pkg::P_SW] |=> $stable(pwr_q)) else $error("battery fault acted");
  chk_vnr_backup: assert property (fault_evt && fault_idx == 3'h4 && backup_ok
    && lvl_q[pfs_pkg::P_SW] |=> pwr_q == pfs_pkg::PWR_BATT) else $error("no battery switch");
  chk_fault_select: assert property (fault_evt && int_en_q && !status_request_cmd
    && !io_reset_cmd |=> sel_q == pfs_pkg::SEL_FAULT ##0 done) else $error("no preselect");
  chk_no_early_pwr: assert property (pwr_q == pfs_pkg::PWR_TEST
    |=> !power_enable) else $error("power during test");
endmodule

// file: shared/pfs_pkg.sv
package pfs_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int OC_PERSIST_US = 1000;
  localparam longint SLOW_PERSIST_S = 15;
  localparam int RESP_DELAY_US = 2000;
  localparam int SELFTEST_US = 100;
  localparam int BLINK_US = 250000;
  localparam int OC_PERSIST_CYC = OC_PERSIST_US * CLK_MHZ;
  localparam longint SLOW_PERSIST_CYC = SLOW_PERSIST_S * 64'd1000000 * CLK_MHZ;
  localparam int RESP_DELAY_CYC = RESP_DELAY_US * CLK_MHZ;
  localparam int SELFTEST_CYC = SELFTEST_US * CLK_MHZ;
  localparam int BLINK_CYC = BLINK_US * CLK_MHZ;
  // ----------------------------------------
  // selector codes and fields
  // ----------------------------------------
  localparam logic [2:0] SEL_CTRL = 3'h0;
  localparam logic [2:0] SEL_BATT = 3'h2;
  localparam logic [2:0] SEL_FAULT = 3'h3;
  localparam logic [2:0] SEL_REV = 3'h4;
  localparam int CTL_JUMPER = 4;
  localparam int CTL_PFMASK = 3;
  localparam int CTL_INT = 2;
  localparam int CTL_BATT_OFF = 1;
  localparam int CTL_ADDR_HI = 7;
  localparam int CTL_ADDR_LO = 6;
  localparam int BW_PARTIAL = 3;
  localparam int BW_FULL = 2;
  localparam int BW_ON = 1;
  localparam int BW_RECHARGE = 0;
  localparam logic [15:0] DEVICE_CODE = 16'h0004;
  localparam logic [7:0] FW_REVISION = 8'h00;
  // ----------------------------------------
  // fault inputs and codes
  // ----------------------------------------
  localparam int NF = 6;
  localparam int F_OV = 0;
  localparam int F_OC = 1;
  localparam int F_TEMP = 2;
  localparam int F_FAN = 3;
  localparam int F_UNREG = 4;
  localparam int F_BATT = 5;
  localparam logic [6:0] CODE_NONE = 7'h00;
  localparam logic [6:0] CODE_OV = 7'h05;
  localparam logic [6:0] CODE_OC = 7'h06;
  localparam logic [6:0] CODE_TEMP = 7'h19;
  localparam logic [6:0] CODE_FAN = 7'h02;
  localparam logic [6:0] CODE_UNREG = 7'h09;
  localparam logic [6:0] CODE_BATT = 7'h0b;
  localparam logic [6:0] CODE_ROM = 7'h07;
  localparam logic [6:0] CODE_LAMP = 7'h7f;
  localparam logic [2:0] LAMPS_ALL = 3'h7;
  // pin vector: faults, then switch, jumper, partial, full, charging, rom bad
  localparam int P_SW = 6;
  localparam int P_JMP = 7;
  localparam int P_PARTIAL = 8;
  localparam int P_FULL = 9;
  localparam int P_RECHARGE = 10;
  localparam int P_ROM = 11;
  localparam int NP = 12;
  typedef enum logic [4:0] {
    PWR_OFF = 5'b00001,
    PWR_TEST = 5'b00010,
    PWR_ON = 5'b00100,
    PWR_BATT = 5'b01000,
    PWR_DOWN = 5'b10000
  } pfs_pwr_t;
endpackage

// file: tb/pfs_host_model.sv
`timescale 1ns/1ps
module pfs_host_model (
  // clock and answers
  input wire logic clk,
  input wire logic done,
  input wire logic [15:0] acc_out,
  // commands to the supervisor
  output logic status_request_cmd,
  output logic status_read_cmd,
  output logic control_write_cmd,
  output logic clear_flag_cmd,
  output logic io_reset_cmd,
  output logic interrupt_acknowledge_cmd,
  output logic [15:0] acc_in
);
  task automatic idle();
    {status_request_cmd, status_read_cmd, control_write_cmd} = 3'h0;
    {clear_flag_cmd, io_reset_cmd, interrupt_acknowledge_cmd} = 3'h0;
  endtask

  initial begin
    idle();
    acc_in = 16'h0000;
  end

  // one-cycle pulse, data held across the taking edge
  task automatic pulse(input int k, input logic [15:0] d);
    @(negedge clk);
    acc_in = d;
    case (k)
      0: status_request_cmd = 1'b1;
      1: status_read_cmd = 1'b1;
      2: control_write_cmd = 1'b1;
      3: clear_flag_cmd = 1'b1;
      4: io_reset_cmd = 1'b1;
      default: interrupt_acknowledge_cmd = 1'b1;
    endcase
    @(negedge clk);
    idle();
    // accumulator not meaningful now, so never leave the old value
    acc_in = ~d;
  endtask

  task automatic wait_done(output bit ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 40 && !ok; n++) begin
      @(negedge clk);
      ok = (done === 1'b1);
    end
  endtask

  task automatic get(input logic [2:0] sel, output logic [15:0] w, output bit ok);
    pulse(0, {13'h0000, sel});
    wait_done(ok);
    pulse(1, 16'h0000);
    w = acc_out;
  endtask
endmodule

// file: tb/pfs_top_tb.sv
`timescale 1ns/1ps
module pfs_top_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] fp = 6'h00;
  logic pw = 1'b0;
  logic rom = 1'b0;
  logic jumper = 1'b1;
  logic part_bk = 1'b1;
  logic full_bk = 1'b0;
  logic charging = 1'b1;
  logic req, rd, wr, clr, iorst, ack, busy, done, irq;
  logic pe, onb, nmi, pff;
  logic [2:0] lamps;
  logic [15:0] ain, aout, w;
  bit ok;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic [15:0] tw [9] = '{16'h000c, 16'h0002, 16'h00c8, 16'h0040, 16'h0000,
                          16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [2:0] ts [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1};
  logic [15:0] te [9] = '{16'h001c, 16'h0012, 16'h0012, 16'h0012, 16'h0009,
                          16'h0000, 16'h0000, 16'h0000, 16'h0000};

  always #2 clk = ~clk;

  pfs_top #(.OC_PERSIST(8), .SLOW_PERSIST(16), .RESP_DELAY(4), .SELFTEST(8), .BLINK(4)) i_dut (
    .clk(clk), .rstn(rstn), .status_request_cmd(req), .status_read_cmd(rd),
    .control_write_cmd(wr), .clear_flag_cmd(clr), .io_reset_cmd(iorst),
    .interrupt_acknowledge_cmd(ack), .acc_in(ain), .acc_out(aout), .busy(busy),
    .done(done), .irq(irq), .fault_pins(fp), .power_switch(pw),
    .margin_jumper_flag(jumper), .partial_backup_present(part_bk),
    .full_backup_present(full_bk), .recharging_flag(charging), .rom_checksum_bad(rom),
    .power_enable(pe), .on_battery_flag(onb), .powerfail_nmi(nmi),
    .powerfail_flag(pff), .lamps(lamps)
  );

  pfs_host_model i_host (
    .clk(clk), .done(done), .acc_out(aout), .status_request_cmd(req),
    .status_read_cmd(rd), .control_write_cmd(wr), .clear_flag_cmd(clr),
    .io_reset_cmd(iorst), .interrupt_acknowledge_cmd(ack), .acc_in(ain)
  );

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic final_report();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t flag got=%h exp=%h", $time, got, exp);
    end
  endtask

  // watched outputs by number; 5 and up compare the lamps with k-8
  function automatic logic sig(input int k);
    case (k)
      0: return done;
      1: return pe;
      2: return onb;
      3: return nmi;
      4: return irq;
      default: return lamps === 3'(k - 8);
    endcase
  endfunction

  task automatic wait_eq(input int k, input logic v, input int lim);
    for (int n = 0; n < lim && sig(k) !== v; n++) @(negedge clk);
    chk_flag(sig(k), v);
  endtask

  task automatic hold_eq(input int k, input logic v, input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (sig(k) !== v) bad = 1'b1;
    end
    chk_flag(bad, 1'b0);
  endtask

  task automatic power_cycle(input logic up);
    pw = 1'b0;
    repeat (10) @(negedge clk);
    pw = 1'b1;
    wait_eq(15, 1'b1, 12);
    chk_flag(pe, 1'b0);
    if (up) wait_eq(1, 1'b1, 40);
    else hold_eq(1, 1'b0, 30);
  endtask

  task automatic setup(input logic [15:0] c);
    i_host.pulse(2, c);
    i_host.wait_done(ok);
    i_host.pulse(3, 16'h0000);
  endtask

  // hang guard, sized well above the whole sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    chk_flag(busy | done | irq | pe, 1'b0);
    chk_word(aout, 16'h0000);
    power_cycle(1'b1);
    for (int i = 0; i < 9; i++) begin
      i_host.pulse(2, tw[i]);
      chk_flag(busy & ~done, 1'b1);
      i_host.wait_done(ok);
      i_host.get(ts[i], w, ok);
      chk_flag(ok, 1'b1);
      chk_word(w, te[i]);
      chk_flag(irq, i == 0);
    end
    i_host.pulse(3, 16'h0000);
    chk_flag(busy | done, 1'b0);
    // other pin levels must reach the status words
    {jumper, part_bk, full_bk, charging} = 4'h2;
    i_host.get(3'h2, w, ok);
    chk_word(w, 16'h0004);
    i_host.get(3'h0, w, ok);
    chk_word(w, 16'h0000);
    {jumper, part_bk, full_bk, charging} = 4'hd;
    // interrupts on after the pin checks, control selected
    setup(16'h0004);
    i_host.get(3'h0, w, ok);
    chk_word(w, 16'h0014);
    i_host.pulse(3, 16'h0000);
    // short overcurrent must not trip
    fp[1] = 1'b1;
    repeat (5) @(negedge clk);
    fp[1] = 1'b0;
    hold_eq(1, 1'b1, 20);
    i_host.pulse(3, 16'h0000);
    fp[1] = 1'b1;
    hold_eq(1, 1'b1, 6);
    wait_eq(1, 1'b0, 30);
    wait_eq(0, 1'b1, 10);
    wait_eq(4, 1'b1, 4);
    wait_eq(14, 1'b1, 20);
    fp[1] = 1'b0;
    i_host.pulse(1, 16'h0000);
    chk_word(aout, 16'h0006);
    i_host.pulse(5, 16'h0000);
    chk_word(aout, 16'h0004);
    i_host.pulse(3, 16'h0000);
    chk_flag(done, 1'b0);
    @(negedge clk);
    chk_flag(irq, 1'b0);
    power_cycle(1'b1);
    fp[0] = 1'b1;
    wait_eq(1, 1'b0, 8);
    fp[0] = 1'b0;
    i_host.pulse(1, 16'h0000);
    chk_word(aout, 16'h0005);
    // unregulated undervoltage with backup usable, then with backup switched off
    power_cycle(1'b1);
    fp[4] = 1'b1;
    wait_eq(2, 1'b1, 10);
    chk_flag(pe, 1'b1);
    fp[4] = 1'b0;
    wait_eq(2, 1'b0, 10);
    setup(16'h0006);
    fp[4] = 1'b1;
    wait_eq(3, 1'b1, 10);
    chk_flag(pff, 1'b1);
    wait_eq(1, 1'b0, 10);
    fp[4] = 1'b0;
    power_cycle(1'b1);
    setup(16'h000e);
    fp[4] = 1'b1;
    hold_eq(3, 1'b0, 12);
    chk_flag(pff, 1'b0);
    fp[4] = 1'b0;
    power_cycle(1'b1);
    setup(16'h0004);
    fp[5] = 1'b1;
    wait_eq(0, 1'b1, 10);
    hold_eq(1, 1'b1, 8);
    i_host.pulse(1, 16'h0000);
    chk_word(aout, 16'h000b);
    fp[5] = 1'b0;
    i_host.pulse(4, 16'h0000);
    chk_flag(done, 1'b0);
    i_host.get(3'h3, w, ok);
    chk_word(w, 16'h000b);
    chk_flag(irq, 1'b0);
    rom = 1'b1;
    power_cycle(1'b0);
    i_host.get(3'h3, w, ok);
    chk_word(w, 16'h0007);
    // reset again in mid-run: outputs fall at once and are still low a cycle later
    rstn = 1'b0;
    @(negedge clk);
    rstn = 1'b1;
    chk_flag(busy | done | irq | pe | onb | nmi | pff, 1'b0);
    chk_word(aout, 16'h0000);
    @(negedge clk);
    chk_flag(pe | (lamps != 3'h0), 1'b0);
    final_report();
  end
endmodule
